// ==== rtl/icw_pkg.sv ====
// Purpose: shared constants for the identify capability words block
// Assumes: 32-bit axi4-lite register bus, identify words are 16 bits
// Notes: identify word n is readable at byte address n*4
`default_nettype none

package icw_pkg;

  // bus geometry
  localparam int unsigned ICW_ADDR_W = 12;
  localparam int unsigned ICW_DATA_W = 32;

  // control register byte offsets
  localparam logic [11:0] ICW_FEAT_OFS = 12'h000;
  localparam logic [11:0] ICW_TIME0_OFS = 12'h004;
  localparam logic [11:0] ICW_TIME1_OFS = 12'h008;
  localparam logic [11:0] ICW_MODE_OFS = 12'h00c;
  localparam logic [11:0] ICW_STAT_OFS = 12'h010;

  // control register values after reset
  localparam logic [31:0] ICW_FEAT_RST = 32'h0000_0000;
  localparam logic [31:0] ICW_TIME0_RST = 32'h0000_0000;
  localparam logic [31:0] ICW_TIME1_RST = 32'h0000_0000;

  // feature register fields
  localparam int unsigned ICW_SUP_LSB = 0;
  localparam int unsigned ICW_EN_LSB = 4;
  localparam int unsigned ICW_ERASE_LSB = 8;
  localparam int unsigned ICW_UMAX_LSB = 16;
  localparam int unsigned ICW_USUP_BIT = 19;
  localparam int unsigned ICW_MLVL_LSB = 20;
  localparam int unsigned ICW_PIOADV_BIT = 22;

  // index inside the four-bit support and enable groups
  localparam int unsigned ICW_F_SEC = 0;
  localparam int unsigned ICW_F_WC = 1;
  localparam int unsigned ICW_F_LA = 2;
  localparam int unsigned ICW_F_APM = 3;

  // mode select register fields
  localparam int unsigned ICW_KIND_LSB = 0;
  localparam int unsigned ICW_MODE_LSB = 4;
  localparam int unsigned ICW_MSEL_LSB = 16;

  // identify word indices handled here
  localparam logic [7:0] ICW_W66 = 8'h42;
  localparam logic [7:0] ICW_W67 = 8'h43;
  localparam logic [7:0] ICW_W68 = 8'h44;
  localparam logic [7:0] ICW_W82 = 8'h52;
  localparam logic [7:0] ICW_W83 = 8'h53;
  localparam logic [7:0] ICW_W84 = 8'h54;
  localparam logic [7:0] ICW_W85 = 8'h55;
  localparam logic [7:0] ICW_W86 = 8'h56;
  localparam logic [7:0] ICW_W87 = 8'h57;
  localparam logic [7:0] ICW_W88 = 8'h58;
  localparam logic [7:0] ICW_W89 = 8'h59;

  // fixed word patterns and bit positions inside words
  localparam logic [15:0] ICW_W82_FIXED = 16'h7008;
  localparam logic [15:0] ICW_W82_MASK = 16'hff9d;
  localparam logic [15:0] ICW_W83_FIXED = 16'h4004;
  localparam logic [15:0] ICW_W84_FIXED = 16'h4000;
  localparam logic [15:0] ICW_W86_FIXED = 16'h0004;
  localparam logic [15:0] ICW_W87_FIXED = 16'h4000;
  localparam int unsigned ICW_B_SEC = 1;
  localparam int unsigned ICW_B_APM = 3;
  localparam int unsigned ICW_B_WC = 5;
  localparam int unsigned ICW_B_LA = 6;

  // dma mode counts
  localparam int unsigned ICW_UDMA_N = 7;
  localparam int unsigned ICW_MDMA_N = 3;

  // bus responses
  localparam logic [1:0] ICW_RESP_OKAY = 2'h0;
  localparam logic [1:0] ICW_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ICW_SEL_NONE, ICW_SEL_MDMA, ICW_SEL_UDMA, ICW_SEL_RSVD} icw_selk_t;

endpackage

`default_nettype wire

// ==== rtl/icw_regs.sv ====
// Purpose: identify words 66..89 with their settings over axi4-lite
// Assumes: one clock, synchronous active-low reset, host read port in same domain
// Notes: timing words are sanitised one cycle after a settings write
`timescale 1ns/1ps
`default_nettype none

module icw_regs #(
  parameter int unsigned ADDR_W = icw_pkg::ICW_ADDR_W
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // identify word read port
  input wire logic id_req,
  input wire logic [7:0] id_word,
  output logic id_ack,
  output logic [15:0] id_rdata,
  // status toward the rest of the card
  output logic ext_fields_valid,
  output logic sec_erase_cmd_en
);
  import icw_pkg::*;

  // settings registers
  logic [31:0] feat_ff;
  logic [31:0] time0_ff;
  logic [31:0] time1_ff;
  logic [3:0] feat_sup;
  logic [3:0] feat_en;
  logic [7:0] erase_time;
  logic [2:0] udma_max;
  logic udma_on;
  logic [1:0] mdma_lvl;
  logic pio_adv;
  logic [15:0] cfg65;
  logic [15:0] cfg66;
  logic [15:0] cfg67;
  logic [15:0] cfg68;

  assign feat_sup = feat_ff[ICW_SUP_LSB +: 4];
  assign feat_en = feat_ff[ICW_EN_LSB +: 4];
  assign erase_time = feat_ff[ICW_ERASE_LSB +: 8];
  assign udma_max = feat_ff[ICW_UMAX_LSB +: 3];
  assign udma_on = feat_ff[ICW_USUP_BIT];
  assign mdma_lvl = feat_ff[ICW_MLVL_LSB +: 2];
  assign pio_adv = feat_ff[ICW_PIOADV_BIT];
  assign cfg65 = time0_ff[15:0];
  assign cfg66 = time0_ff[31:16];
  assign cfg67 = time1_ff[15:0];
  assign cfg68 = time1_ff[31:16];

  // write channel state
  logic aw_have_ff;
  logic w_have_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic nxt_aw_have;
  logic nxt_w_have;
  logic nxt_bvalid;
  logic wr_feat;
  logic wr_time0;
  logic wr_time1;
  logic wr_mode;

  assign aw_take = awvalid && awready_ff;
  assign w_take = wvalid && wready_ff;
  // both halves in hand and the previous response gone
  assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
  assign nxt_aw_have = wr_fire ? 1'b0 : (aw_have_ff || aw_take);
  assign nxt_w_have = wr_fire ? 1'b0 : (w_have_ff || w_take);
  assign nxt_bvalid = wr_fire ? 1'b1 : (bvalid_ff && !bready);
  assign wr_feat = aw_addr_ff == ICW_FEAT_OFS;
  assign wr_time0 = aw_addr_ff == ICW_TIME0_OFS;
  assign wr_time1 = aw_addr_ff == ICW_TIME1_OFS;
  assign wr_mode = aw_addr_ff == ICW_MODE_OFS;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= ICW_RESP_OKAY;
    end else begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      if (aw_take) begin
        aw_addr_ff <= awaddr;
      end
      if (w_take) begin
        w_data_ff <= wdata;
        w_strb_ff <= wstrb;
      end
      // one write at a time: no new halves until the response is taken
      awready_ff <= !nxt_aw_have && !nxt_bvalid;
      wready_ff <= !nxt_w_have && !nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      if (wr_fire) begin
        bresp_ff <= (wr_feat || wr_time0 || wr_time1 || wr_mode) ? ICW_RESP_OKAY : ICW_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      feat_ff <= ICW_FEAT_RST;
      time0_ff <= ICW_TIME0_RST;
      time1_ff <= ICW_TIME1_RST;
    end else if (wr_fire) begin
      if (wr_feat) begin
        feat_ff <= merge(feat_ff, w_data_ff, w_strb_ff);
      end
      if (wr_time0) begin
        time0_ff <= merge(time0_ff, w_data_ff, w_strb_ff);
      end
      if (wr_time1) begin
        time1_ff <= merge(time1_ff, w_data_ff, w_strb_ff);
      end
    end
  end

  // sanitised cycle-time words
  logic [15:0] w65_ff;
  logic [15:0] w66_ff;
  logic [15:0] w67_ff;
  logic [15:0] w68_ff;
  logic ext_valid_ff;
  logic need66;
  logic [15:0] nxt_w66;
  logic [15:0] nxt_w67;

  assign need66 = mdma_lvl >= 2'h2;
  // zero means not implemented unless the field is mandatory
  assign nxt_w66 = (cfg66 == 16'h0000) ? (need66 ? cfg65 : 16'h0000) :
                   ((cfg66 < cfg65) ? cfg65 : cfg66);
  assign nxt_w67 = (cfg67 == 16'h0000) ? (pio_adv ? cfg68 : 16'h0000) :
                   ((cfg67 < cfg68) ? cfg68 : cfg67);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w65_ff <= 16'h0000;
      w66_ff <= 16'h0000;
      w67_ff <= 16'h0000;
      w68_ff <= 16'h0000;
      ext_valid_ff <= 1'b0;
    end else begin
      w65_ff <= cfg65;
      w66_ff <= nxt_w66;
      w67_ff <= nxt_w67;
      w68_ff <= cfg68;
      // advanced pio obliges the 64-70 fields, so the flag goes up too
      ext_valid_ff <= pio_adv || (cfg65 != 16'h0000) || (nxt_w66 != 16'h0000) ||
                      (nxt_w67 != 16'h0000) || (cfg68 != 16'h0000);
    end
  end

  // dma support masks and selection
  logic [6:0] udma_sup_mask;
  logic [2:0] mdma_sup_mask;
  logic [6:0] udma_sel_ff;
  logic [2:0] mdma_sel_ff;
  logic mode_wr;
  icw_selk_t sel_kind;
  logic [2:0] sel_mode;
  logic [7:0] udma_mask_x;
  logic [3:0] mdma_mask_x;
  logic udma_ok;
  logic mdma_ok;
  logic [6:0] udma_onehot;
  logic [2:0] mdma_onehot;

  for (genvar i = 0; i < ICW_UDMA_N; i++) begin : g_udma
    assign udma_sup_mask[i] = udma_on && (3'(i) <= udma_max);
  end
  for (genvar j = 0; j < ICW_MDMA_N; j++) begin : g_mdma
    assign mdma_sup_mask[j] = 2'(j) < mdma_lvl;
  end

  assign mode_wr = wr_fire && wr_mode && w_strb_ff[0];
  assign sel_kind = icw_selk_t'(w_data_ff[ICW_KIND_LSB +: 2]);
  assign sel_mode = w_data_ff[ICW_MODE_LSB +: 3];
  assign udma_mask_x = {1'b0, udma_sup_mask};
  assign mdma_mask_x = {1'b0, mdma_sup_mask};
  assign udma_ok = udma_mask_x[sel_mode];
  assign mdma_ok = !sel_mode[2] && mdma_mask_x[sel_mode[1:0]];
  assign udma_onehot = 7'h01 << sel_mode;
  assign mdma_onehot = 3'h1 << sel_mode[1:0];

  // a request for an unsupported mode is ignored, old selection stays
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      udma_sel_ff <= 7'h00;
      mdma_sel_ff <= 3'h0;
    end else if (mode_wr) begin
      unique case (sel_kind)
        ICW_SEL_NONE: begin
          udma_sel_ff <= 7'h00;
          mdma_sel_ff <= 3'h0;
        end
        ICW_SEL_UDMA: begin
          if (udma_ok) begin
            udma_sel_ff <= udma_onehot;
            mdma_sel_ff <= 3'h0;
          end
        end
        ICW_SEL_MDMA: begin
          if (mdma_ok) begin
            mdma_sel_ff <= mdma_onehot;
            udma_sel_ff <= 7'h00;
          end
        end
        ICW_SEL_RSVD: begin
          udma_sel_ff <= udma_sel_ff;
        end
      endcase
    end else begin
      // withdrawn support drops a selection that no longer holds
      udma_sel_ff <= udma_sel_ff & udma_sup_mask;
      mdma_sel_ff <= mdma_sel_ff & mdma_sup_mask;
    end
  end

  // word encoders, one per reader so neither waits on the other
  logic [15:0] bus_word;
  logic [15:0] id_word_val;
  logic [7:0] ar_idx;

  assign ar_idx = araddr[9:2];

  icw_word_enc u_bus_enc (
    .word_idx(ar_idx),
    .w66(w66_ff),
    .w67(w67_ff),
    .w68(w68_ff),
    .feat_sup(feat_sup),
    .feat_en(feat_en),
    .udma_sup(udma_sup_mask),
    .udma_sel(udma_sel_ff),
    .erase_time(erase_time),
    .word_val(bus_word)
  );

  icw_word_enc u_id_enc (
    .word_idx(id_word),
    .w66(w66_ff),
    .w67(w67_ff),
    .w68(w68_ff),
    .feat_sup(feat_sup),
    .feat_en(feat_en),
    .udma_sup(udma_sup_mask),
    .udma_sel(udma_sel_ff),
    .erase_time(erase_time),
    .word_val(id_word_val)
  );

  // read channel
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic ar_take;
  logic nxt_rvalid;
  logic in_window;
  logic [31:0] rd_data;
  logic rd_ok;

  assign ar_take = arvalid && arready_ff;
  assign nxt_rvalid = ar_take ? 1'b1 : (rvalid_ff && !rready);
  assign in_window = (araddr[ADDR_W-1:10] == '0) && (araddr[1:0] == 2'h0) &&
                     (ar_idx >= ICW_W66) && (ar_idx <= ICW_W88 + 8'h01);

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    if (in_window) begin
      rd_data = {16'h0000, bus_word};
    end else if (araddr == ICW_FEAT_OFS) begin
      rd_data = feat_ff;
    end else if (araddr == ICW_TIME0_OFS) begin
      rd_data = time0_ff;
    end else if (araddr == ICW_TIME1_OFS) begin
      rd_data = time1_ff;
    end else if (araddr == ICW_MODE_OFS) begin
      rd_data = {13'h0, mdma_sel_ff, 1'b0, udma_sel_ff, 1'b0, udma_sup_mask};
    end else if (araddr == ICW_STAT_OFS) begin
      rd_data = {30'h0, (udma_sel_ff != 7'h00) || (mdma_sel_ff != 3'h0), ext_valid_ff};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= ICW_RESP_OKAY;
    end else begin
      arready_ff <= !nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_take) begin
        rdata_ff <= rd_data;
        rresp_ff <= rd_ok ? ICW_RESP_OKAY : ICW_RESP_SLVERR;
      end
    end
  end

  // identify port: answer one cycle after the request, data held after
  logic id_ack_ff;
  logic [15:0] id_rdata_ff;
  logic sec_cmd_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      id_ack_ff <= 1'b0;
      id_rdata_ff <= 16'h0000;
      sec_cmd_ff <= 1'b0;
    end else begin
      id_ack_ff <= id_req;
      if (id_req) begin
        id_rdata_ff <= id_word_val;
      end
      sec_cmd_ff <= feat_sup[ICW_F_SEC];
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign id_ack = id_ack_ff;
  assign id_rdata = id_rdata_ff;
  assign ext_fields_valid = ext_valid_ff;
  assign sec_erase_cmd_en = sec_cmd_ff;

  sequence s_id_read(logic [7:0] idx);
    id_req && (id_word == idx);
  endsequence

  sequence s_udma_write;
    mode_wr && (sel_kind == ICW_SEL_UDMA) && udma_ok;
  endsequence

  property p_w66_floor;
    @(posedge aclk) disable iff (!aresetn) (w66_ff != 16'h0000) |-> (w66_ff >= w65_ff);
  endproperty
  a_w66_floor: assert property (p_w66_floor) else $error("word 66 below word 65");

  property p_w66_needed;
    @(posedge aclk) disable iff (!aresetn) (need66 && cfg65 != 16'h0000) |=> (w66_ff != 16'h0000);
  endproperty
  a_w66_needed: assert property (p_w66_needed) else $error("word 66 missing for dma mode 1 up");

  property p_w67_floor;
    @(posedge aclk) disable iff (!aresetn) (w67_ff != 16'h0000) |-> (w67_ff >= w68_ff);
  endproperty
  a_w67_floor: assert property (p_w67_floor) else $error("word 67 below word 68");

  property p_w83_marker;
    @(posedge aclk) disable iff (!aresetn) s_id_read(ICW_W83) |=> id_ack && (id_rdata[15:14] == 2'h1);
  endproperty
  a_w83_marker: assert property (p_w83_marker) else $error("word 83 valid marker wrong");

  property p_w82_fixed;
    @(posedge aclk) disable iff (!aresetn)
      s_id_read(ICW_W82) |=> ((id_rdata & ICW_W82_MASK) == ICW_W82_FIXED) && (id_rdata[1] == $past(feat_sup[0]));
  endproperty
  a_w82_fixed: assert property (p_w82_fixed) else $error("word 82 pattern wrong");

  property p_w87_fixed;
    @(posedge aclk) disable iff (!aresetn) s_id_read(ICW_W87) |=> (id_rdata == ICW_W87_FIXED);
  endproperty
  a_w87_fixed: assert property (p_w87_fixed) else $error("word 87 not valid marker");

  property p_one_dma;
    @(posedge aclk) disable iff (!aresetn) $onehot0({udma_sel_ff, mdma_sel_ff});
  endproperty
  a_one_dma: assert property (p_one_dma) else $error("more than one dma mode selected");

  property p_udma_select;
    @(posedge aclk) disable iff (!aresetn) s_udma_write |=> (udma_sel_ff == $past(udma_onehot)) && (mdma_sel_ff == 3'h0);
  endproperty
  a_udma_select: assert property (p_udma_select) else $error("ultra dma selection not taken");

  property p_udma_cumul;
    @(posedge aclk) disable iff (!aresetn) (((udma_sup_mask + 7'h01) & udma_sup_mask) == 7'h00);
  endproperty
  a_udma_cumul: assert property (p_udma_cumul) else $error("ultra dma support not cumulative");

  property p_w89_nosec;
    @(posedge aclk) disable iff (!aresetn) s_id_read(ICW_W89) ##0 !feat_sup[ICW_F_SEC] |=> (id_rdata == 16'h0000);
  endproperty
  a_w89_nosec: assert property (p_w89_nosec) else $error("erase time without security");

  property p_ext_flag;
    @(posedge aclk) disable iff (!aresetn) (w66_ff != 16'h0000 || w68_ff != 16'h0000) |-> ext_valid_ff;
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("extended fields flag low");

  property p_read_answer;
    @(posedge aclk) disable iff (!aresetn) (arvalid && arready) |=> rvalid ##0 !arready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered next cycle");

endmodule

`default_nettype wire

// ==== rtl/icw_word_enc.sv ====
// Purpose: formats one identify word (66..89) from the current settings
// Assumes: all inputs are already consistent register values
// Notes: purely combinational, so reading a word never changes anything
`timescale 1ns/1ps
`default_nettype none

module icw_word_enc (
  // selection
  input wire logic [7:0] word_idx,
  // timing words
  input wire logic [15:0] w66,
  input wire logic [15:0] w67,
  input wire logic [15:0] w68,
  // feature settings
  input wire logic [3:0] feat_sup,
  input wire logic [3:0] feat_en,
  input wire logic [6:0] udma_sup,
  input wire logic [6:0] udma_sel,
  input wire logic [7:0] erase_time,
  // result
  output logic [15:0] word_val
);
  import icw_pkg::*;

  always_comb begin
    word_val = 16'h0000;
    case (word_idx)
      ICW_W66: word_val = w66;
      ICW_W67: word_val = w67;
      ICW_W68: word_val = w68;
      ICW_W82: begin
        word_val = ICW_W82_FIXED;
        word_val[ICW_B_SEC] = feat_sup[ICW_F_SEC];
        word_val[ICW_B_WC] = feat_sup[ICW_F_WC];
        word_val[ICW_B_LA] = feat_sup[ICW_F_LA];
      end
      ICW_W83: begin
        word_val = ICW_W83_FIXED;
        word_val[ICW_B_APM] = feat_sup[ICW_F_APM];
      end
      ICW_W84: word_val = ICW_W84_FIXED;
      ICW_W85: begin
        // enabled bits never claim more than what is supported
        word_val = ICW_W82_FIXED;
        word_val[ICW_B_SEC] = feat_en[ICW_F_SEC] & feat_sup[ICW_F_SEC];
        word_val[ICW_B_WC] = feat_en[ICW_F_WC] & feat_sup[ICW_F_WC];
        word_val[ICW_B_LA] = feat_en[ICW_F_LA] & feat_sup[ICW_F_LA];
      end
      ICW_W86: begin
        word_val = ICW_W86_FIXED;
        word_val[ICW_B_APM] = feat_en[ICW_F_APM] & feat_sup[ICW_F_APM];
      end
      ICW_W87: word_val = ICW_W87_FIXED;
      ICW_W88: word_val = {1'b0, udma_sel, 1'b0, udma_sup};
      // erase time only means something when security is there
      ICW_W89: word_val = feat_sup[ICW_F_SEC] ? {8'h00, erase_time} : 16'h0000;
      // words 69, 70 and the gap up to 81 are not implemented: zero
      default: word_val = 16'h0000;
    endcase
  end

endmodule

`default_nettype wire

// ==== test/icw_host_model.sv ====
// Purpose: host side reader of identify words
// Assumes: same clock as the card
// Notes: idle word lines toggle so a stale number never looks like a request
`timescale 1ns/1ps
`default_nettype none
module icw_host_model (
  // bench control
  input wire logic aclk,
  input wire logic go,
  input wire logic [7:0] word_in,
  output logic [15:0] data = 16'h0,
  output logic done = 1'b0,
  output logic indicated = 1'b0,
  // identify port
  output logic id_req = 1'b0,
  output logic [7:0] id_word = 8'h0,
  input wire logic id_ack,
  input wire logic [15:0] id_rdata
);
  always @(posedge aclk) begin
    id_req <= go;
    id_word <= go ? word_in : ~id_word;
    done <= id_ack;
    if (id_ack) begin
      data <= id_rdata;
      indicated <= (id_rdata != 16'h0000) && (id_rdata != 16'hffff);
    end
  end
  // feature words are passed up only, nothing here acts on them
endmodule
`default_nettype wire

// ==== test/test_icw_regs.sv ====
// Purpose: self-checking bench for the identify capability words
// Assumes: one clock, settings written over axi4-lite
// Notes: expectations come from bench functions or literal values, never from the design
`timescale 1ns/1ps
`default_nettype none
module test_icw_regs;
  import icw_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, go = 1'b0, ind;
  logic awready, wready, bvalid, arready, rvalid, id_req, id_ack, done;
  logic ext_fields_valid, sec_erase_cmd_en;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [3:0] wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata, f, d;
  logic [1:0] bresp, rresp, r;
  logic [7:0] id_word, wd = 8'h0;
  logic [15:0] id_rdata, hd;
  int num_errors = 0, checked = 0, cyc = 0, seed = 33003;
  initial forever #25 aclk = ~aclk;
  icw_regs u_icw_regs (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot, .rvalid, .rready, .rdata, .rresp, .id_req, .id_word, .id_ack, .id_rdata,
    .ext_fields_valid, .sec_erase_cmd_en);
  icw_host_model u_icw_host_model (.aclk, .go, .word_in(wd), .data(hd), .done,
    .indicated(ind), .id_req, .id_word, .id_ack, .id_rdata);
  task automatic summarize();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= v;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    r = bresp;
    // timing words settle one edge after the write fires
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic idc(input logic [7:0] w, input logic [15:0] e);
    @(posedge aclk);
    go <= 1'b1;
    wd <= w;
    @(posedge aclk);
    go <= 1'b0;
    do @(posedge aclk); while (done !== 1'b1);
    chk("id word", 34'(hd), 34'(e));
    chk("indicated", 34'(ind), 34'((e != 16'h0000) && (e != 16'hffff)));
  endtask
  function automatic logic [15:0] fexp(input logic [7:0] w, input logic [31:0] f);
    logic [3:0] e;
    e = f[7:4] & f[3:0];
    case (w)
      ICW_W82: return 16'h7008 | {9'h0, f[2], f[1], 3'h0, f[0], 1'b0};
      ICW_W83: return 16'h4004 | {12'h0, f[3], 3'h0};
      ICW_W84, ICW_W87: return 16'h4000;
      ICW_W85: return 16'h7008 | {9'h0, e[2], e[1], 3'h0, e[0], 1'b0};
      ICW_W86: return 16'h0004 | {12'h0, e[3], 3'h0};
      ICW_W88: return f[19] ? {9'h0, 7'(7'h7f >> (6 - f[18:16]))} : 16'h0;
      ICW_W89: return f[0] ? {8'h0, f[15:8]} : 16'h0;
      default: return 16'h0;
    endcase
  endfunction
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(12'(4 * i));
      chk("reset reg", {r, d}, 34'h0);
    end
    for (int w = 66; w < 90; w++) idc(8'(w), fexp(8'(w), 32'h0));
    $display("done: reset words");
    for (int i = 0; i < 8; i++) begin
      f = $random(seed) & 32'h000f_ffff;
      f[18:16] = f[18:16] % 3'h7;
      wr(ICW_FEAT_OFS, f);
      chk("erase cmd", 34'(sec_erase_cmd_en), 34'(f[0]));
      for (int w = 82; w < 90; w++) idc(8'(w), fexp(8'(w), f));
      rd(12'(88 * 4));
      chk("bus word 88", {r, d}, 34'(fexp(ICW_W88, f)));
    end
    $display("done: random features");
    wr(ICW_FEAT_OFS, 32'h0060_0000);
    wr(ICW_TIME0_OFS, 32'h0000_0078);
    wr(ICW_TIME1_OFS, 32'h0064_0000);
    idc(ICW_W66, 16'h0078);
    idc(ICW_W67, 16'h0064);
    idc(ICW_W68, 16'h0064);
    chk("ext valid", 34'(ext_fields_valid), 34'h1);
    wr(ICW_TIME0_OFS, 32'h0050_0078);
    idc(ICW_W66, 16'h0078);
    wr(ICW_TIME1_OFS, 32'h0064_005a);
    idc(ICW_W67, 16'h0064);
    wr(ICW_TIME0_OFS, 32'h0096_0078);
    idc(ICW_W66, 16'h0096);
    wr(ICW_FEAT_OFS, 32'h0);
    wr(ICW_TIME1_OFS, 32'h0);
    wr(ICW_TIME0_OFS, 32'h0000_0078);
    idc(ICW_W66, 16'h0);
    idc(ICW_W67, 16'h0);
    chk("ext valid", 34'(ext_fields_valid), 34'h1);
    wr(ICW_TIME0_OFS, 32'h0);
    chk("ext clear", 34'(ext_fields_valid), 34'h0);
    $display("done: timing words");
    wr(ICW_FEAT_OFS, 32'h003e_0000);
    for (int m = 0; m < 7; m++) begin
      wr(ICW_MODE_OFS, 32'(2 + 16 * m));
      idc(ICW_W88, {1'b0, 7'(1 << m), 8'h7f});
    end
    wr(ICW_MODE_OFS, 32'h0000_0011);
    idc(ICW_W88, 16'h007f);
    wr(ICW_MODE_OFS, 32'h0000_0032);
    wr(ICW_FEAT_OFS, 32'h000a_0000);
    idc(ICW_W88, 16'h0007);
    // supported pick, then an unsupported one, a reserved kind and a masked lane: only the first counts
    wr(ICW_MODE_OFS, 32'h0000_0022);
    wr(ICW_MODE_OFS, 32'h0000_0052);
    wr(ICW_MODE_OFS, 32'h0000_0003);
    wstrb <= 4'he;
    wr(ICW_MODE_OFS, 32'h0000_0000);
    wstrb <= 4'h2;
    wr(ICW_FEAT_OFS, 32'hffff_ffff);
    wstrb <= 4'hf;
    rd(ICW_MODE_OFS);
    chk("mode readback", {r, d}, {ICW_RESP_OKAY, 32'h0000_0407});
    idc(ICW_W88, 16'h0407);
    rd(ICW_STAT_OFS);
    chk("status", {r, d}, {ICW_RESP_OKAY, 32'h0000_0002});
    rd(ICW_FEAT_OFS);
    chk("feat merge", {r, d}, {ICW_RESP_OKAY, 32'h000a_ff00});
    $display("done: dma modes");
    wr(ICW_STAT_OFS, 32'h1);
    chk("stat write", 34'(r), 34'(ICW_RESP_SLVERR));
    wr(12'h108, 32'h1);
    chk("window write", 34'(r), 34'(ICW_RESP_SLVERR));
    rd(12'hffc);
    chk("unmapped read", {r, d}, {ICW_RESP_SLVERR, 32'h0});
    $display("done: refusals");
    summarize();
  end
endmodule
`default_nettype wire
